// ---- logic/sensor_core_pkg.sv ----
// package: register map, reset values and carriers for the sensor core register bank
`default_nettype none
package sensor_core_pkg;
  // ----------------------------------------------------------------
  // register offsets (word addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_GESTURE_X1 = 8'h00;
  localparam logic [7:0] ADDR_GESTURE_X2 = 8'h01;
  localparam logic [7:0] ADDR_GESTURE_Y1 = 8'h02;
  localparam logic [7:0] ADDR_GESTURE_Y2 = 8'h03;
  localparam logic [7:0] ADDR_PROX_I = 8'h04;
  localparam logic [7:0] ADDR_PROX_X = 8'h05;
  localparam logic [7:0] ADDR_PROX_Y = 8'h06;
  localparam logic [7:0] ADDR_RESERVED_SEVEN = 8'h07;
  localparam logic [7:0] ADDR_PART_ID = 8'h08;
  localparam logic [7:0] ADDR_TARGET_ADDR = 8'h09;
  localparam logic [7:0] ADDR_OSC_CAL = 8'h0a;
  localparam logic [7:0] ADDR_TIMER_TEST = 8'h0c;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h0f;
  localparam logic [7:0] ADDR_CONV_A = 8'h10;
  localparam logic [7:0] ADDR_CONV_B = 8'h11;
  localparam logic [7:0] ADDR_FE_TRIM = 8'h12;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_RESULT = 16'h0000;
  localparam logic [15:0] RST_RESERVED_SEVEN = 16'h0020;
  localparam logic [15:0] RST_TIMER_TEST = 16'h000f;
  localparam logic [15:0] RST_SOFT_RESET = 16'h0000;
  localparam logic [15:0] RST_CONV_A = 16'h1010;
  localparam logic [15:0] RST_CONV_B = 16'h004c;
  localparam logic [15:0] RST_FE_TRIM = 16'h0008;
  localparam logic [11:0] RST_OSC_CAL = 12'h000;
  localparam int SOFT_RESET_BIT = 0;
  localparam int GAIN_LSB = 0;
  localparam int POLE_LSB = 2;
  localparam int VREF_LSB = 4;
  localparam int PART_ID_W = 12;
  localparam int REVISION_W = 4;
  localparam int TARGET_ADDR_W = 7;
  localparam int OSC_CAL_W = 12;
  localparam int SLOW_EDGES_PER_CAL = 2;

  // ----------------------------------------------------------------
  // front-end trim decodes
  // ----------------------------------------------------------------
  localparam logic [7:0] GAIN_200K = 8'hc8;
  localparam logic [7:0] GAIN_100K = 8'h64;
  localparam logic [7:0] GAIN_50K = 8'h32;
  localparam logic [8:0] POLE_50K = 9'h032;
  localparam logic [8:0] POLE_100K = 9'h064;
  localparam logic [8:0] POLE_300K = 9'h12c;
  localparam logic [3:0] VREF_13 = 4'hd;
  localparam logic [3:0] VREF_12 = 4'hc;
  localparam logic [3:0] VREF_15 = 4'hf;
  localparam logic [3:0] VREF_14 = 4'he;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [19:0] x1;
    logic [19:0] x2;
    logic [19:0] y1;
    logic [19:0] y2;
    logic [19:0] prox_i;
    logic [19:0] prox_x;
    logic [19:0] prox_y;
  } meas_s;

  typedef struct packed {
    logic [7:0] gain_kohm;
    logic [8:0] pole_low_khz;
    logic [8:0] pole_high_khz;
    logic [3:0] vref_sixteenths;
  } trim_s;
endpackage : sensor_core_pkg
`default_nettype wire

// ---- logic/sensor_core_register_bank.sv ----
// module: register bank of the gesture and proximity sensor core
`timescale 1ns/10ps
`default_nettype none
module sensor_core_register_bank
  import sensor_core_pkg::*;
#(
  parameter logic [PART_ID_W-1:0] PART_ID = 12'h5a3,      // arbitrary value
  parameter logic [REVISION_W-1:0] REVISION = 4'h1,       // arbitrary value
  parameter logic [7:0] TARGET_ADDR = 8'hc8
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire meas_s i_meas,
  input wire logic i_slot_end,
  input wire logic i_slow_osc,
  input wire logic i_fast_tick,
  output trim_s o_trim,
  output logic o_soft_reset
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] sat16(input logic [19:0] v);
    sat16 = (|v[19:16]) ? 16'hffff : v[15:0];
  endfunction : sat16

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [15:0] result_reg [7];
  logic [15:0] timer_test_reg;
  logic [15:0] soft_reset_reg;
  logic [15:0] conv_a_reg;
  logic [15:0] conv_b_reg;
  logic [15:0] fe_trim_reg;
  logic [OSC_CAL_W-1:0] osc_cal_reg;
  logic [OSC_CAL_W-1:0] cal_count_reg;
  logic [1:0] slow_edges_reg;
  logic slow_prev_reg;
  logic soft_reset_pulse_reg;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic wr_timer = i_reg_wr && (i_reg_addr == ADDR_TIMER_TEST);
  wire logic wr_soft = i_reg_wr && (i_reg_addr == ADDR_SOFT_RESET);
  wire logic wr_conv_a = i_reg_wr && (i_reg_addr == ADDR_CONV_A);
  wire logic wr_conv_b = i_reg_wr && (i_reg_addr == ADDR_CONV_B);
  wire logic wr_trim = i_reg_wr && (i_reg_addr == ADDR_FE_TRIM);
  // a software reset restores writable and result words, never the identity words
  wire logic sw_clear = soft_reset_pulse_reg;
  wire logic soft_req = wr_soft && i_reg_wdata[SOFT_RESET_BIT];
  wire logic slow_rise = i_slow_osc && !slow_prev_reg;
  wire logic cal_done = slow_rise && (slow_edges_reg == 2'(SLOW_EDGES_PER_CAL));
  wire logic [OSC_CAL_W-1:0] cal_inc = (&cal_count_reg) ? cal_count_reg
                                       : cal_count_reg + 1'b1;

  wire logic [15:0] id_word = {REVISION, PART_ID};
  wire logic [15:0] addr_word = {{(16-TARGET_ADDR_W){1'b0}},
                                 TARGET_ADDR[TARGET_ADDR_W-1:0]};
  logic [15:0] rd_mux;
  always_comb begin
    unique case (i_reg_addr)
      ADDR_GESTURE_X1: rd_mux = result_reg[0];
      ADDR_GESTURE_X2: rd_mux = result_reg[1];
      ADDR_GESTURE_Y1: rd_mux = result_reg[2];
      ADDR_GESTURE_Y2: rd_mux = result_reg[3];
      ADDR_PROX_I: rd_mux = result_reg[4];
      ADDR_PROX_X: rd_mux = result_reg[5];
      ADDR_PROX_Y: rd_mux = result_reg[6];
      ADDR_RESERVED_SEVEN: rd_mux = RST_RESERVED_SEVEN;
      ADDR_PART_ID: rd_mux = id_word;
      ADDR_TARGET_ADDR: rd_mux = addr_word;
      ADDR_OSC_CAL: rd_mux = {{(16-OSC_CAL_W){1'b0}}, osc_cal_reg};
      ADDR_TIMER_TEST: rd_mux = timer_test_reg;
      ADDR_SOFT_RESET: rd_mux = soft_reset_reg;
      ADDR_CONV_A: rd_mux = conv_a_reg;
      ADDR_CONV_B: rd_mux = conv_b_reg;
      ADDR_FE_TRIM: rd_mux = fe_trim_reg;
      default: rd_mux = 16'h0000;
    endcase
  end

  // trim decode
  wire logic [1:0] gain_code = fe_trim_reg[GAIN_LSB +: 2];
  wire logic [1:0] pole_code = fe_trim_reg[POLE_LSB +: 2];
  wire logic [1:0] vref_code = fe_trim_reg[VREF_LSB +: 2];
  // code 3 of the gain is not defined; it is taken as the smallest resistor
  wire logic [7:0] gain_next = (gain_code == 2'd0) ? GAIN_200K
                             : (gain_code == 2'd1) ? GAIN_100K : GAIN_50K;
  wire logic [8:0] pole_lo_next = pole_code[1] ? POLE_100K : POLE_50K;
  wire logic [8:0] pole_hi_next = pole_code[0] ? POLE_300K : POLE_100K;
  wire logic [3:0] vref_next = (vref_code == 2'd0) ? VREF_13
                             : (vref_code == 2'd1) ? VREF_12
                             : (vref_code == 2'd2) ? VREF_15 : VREF_14;
  wire logic [19:0] meas_word [7];
  assign meas_word[0] = i_meas.x1;
  assign meas_word[1] = i_meas.x2;
  assign meas_word[2] = i_meas.y1;
  assign meas_word[3] = i_meas.y2;
  assign meas_word[4] = i_meas.prox_i;
  assign meas_word[5] = i_meas.prox_x;
  assign meas_word[6] = i_meas.prox_y;

  // ----------------------------------------------------------------
  // result words
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < 7; k++) result_reg[k] <= RST_RESULT;
    end else if (sw_clear) begin
      for (int k = 0; k < 7; k++) result_reg[k] <= RST_RESULT;
    end else if (i_slot_end) begin
      for (int k = 0; k < 7; k++) result_reg[k] <= sat16(meas_word[k]);
    end
  end

  // ----------------------------------------------------------------
  // writable words; read-only addresses have no write path
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      timer_test_reg <= RST_TIMER_TEST;
      conv_a_reg <= RST_CONV_A;
      conv_b_reg <= RST_CONV_B;
      fe_trim_reg <= RST_FE_TRIM;
    end else if (sw_clear) begin
      timer_test_reg <= RST_TIMER_TEST;
      conv_a_reg <= RST_CONV_A;
      conv_b_reg <= RST_CONV_B;
      fe_trim_reg <= RST_FE_TRIM;
    end else begin
      if (wr_timer) timer_test_reg <= i_reg_wdata;
      if (wr_conv_a) conv_a_reg <= i_reg_wdata;
      if (wr_conv_b) conv_b_reg <= i_reg_wdata;
      if (wr_trim) fe_trim_reg <= i_reg_wdata;
    end
  end

  // the control bit reads as one for the cycle after the write, then self-clears
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      soft_reset_reg <= RST_SOFT_RESET;
      soft_reset_pulse_reg <= 1'b0;
    end else begin
      soft_reset_reg <= wr_soft ? i_reg_wdata : (sw_clear ? RST_SOFT_RESET : soft_reset_reg);
      soft_reset_pulse_reg <= soft_req;
    end
  end

  // ----------------------------------------------------------------
  // oscillator calibration: ticks between slow edge n and n+2
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      slow_prev_reg <= 1'b0;
      slow_edges_reg <= 2'd0;
      cal_count_reg <= RST_OSC_CAL;
      osc_cal_reg <= RST_OSC_CAL;
    end else begin
      slow_prev_reg <= i_slow_osc;
      if (sw_clear) begin
        slow_edges_reg <= 2'd0;
        cal_count_reg <= RST_OSC_CAL;
        osc_cal_reg <= RST_OSC_CAL;
      end else if (cal_done) begin
        osc_cal_reg <= cal_count_reg;
        cal_count_reg <= RST_OSC_CAL;
        slow_edges_reg <= 2'd1;
      end else begin
        if (slow_rise) slow_edges_reg <= slow_edges_reg + 2'd1;
        if ((slow_edges_reg != 2'd0) && i_fast_tick) cal_count_reg <= cal_inc;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 16'h0000;
      o_reg_rvalid <= 1'b0;
      o_trim <= '0;
      o_soft_reset <= 1'b0;
    end else begin
      o_reg_rdata <= i_reg_rd ? rd_mux : 16'h0000;
      o_reg_rvalid <= i_reg_rd;
      o_trim <= '{gain_next, pole_lo_next, pole_hi_next, vref_next};
      o_soft_reset <= soft_req;
    end
  end

endmodule : sensor_core_register_bank
`default_nettype wire

// ---- testbench/sensor_core_host.sv ----
// word-level host model that issues register requests to the bank
`timescale 1ns/10ps
`default_nettype none
module sensor_core_host (
  input wire logic i_ref_clk,
  output logic [7:0] o_reg_addr,
  output logic o_reg_wr,
  output logic [15:0] o_reg_wdata,
  output logic o_reg_rd
);
  initial begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_wdata = 16'h0000;
    o_reg_rd = 1'b0;
  end
  task automatic write_word(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    #1;
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_wr = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_reg_wr = 1'b0;
    // stale data is inverted so a late sample cannot pass by luck
    o_reg_wdata = ~d;
  endtask : write_word
  task automatic read_word(input logic [7:0] a);
    @(posedge i_ref_clk);
    #1;
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_reg_rd = 1'b0;
  endtask : read_word
endmodule : sensor_core_host
`default_nettype wire

// ---- testbench/sensor_core_register_bank_chk.sv ----
// checker of port timing and port values for the sensor core register bank
`timescale 1ns/10ps
`default_nettype none
module sensor_core_register_bank_chk
  import sensor_core_pkg::*;
#(
  parameter logic [PART_ID_W-1:0] PART_ID = 12'h000,
  parameter logic [REVISION_W-1:0] REVISION = 4'h0,
  parameter logic [7:0] TARGET_ADDR = 8'h00
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire meas_s i_meas,
  input wire logic i_slot_end,
  input wire logic i_slow_osc,
  input wire logic i_fast_tick,
  input wire trim_s o_trim,
  input wire logic o_soft_reset
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  function automatic logic [15:0] sat16(input logic [19:0] v);
    return (v > 20'h0ffff) ? 16'hffff : v[15:0];
  endfunction : sat16
  sequence s_load_then_read;
    i_slot_end ##2 (i_reg_rd && i_reg_addr == ADDR_PROX_I);
  endsequence
  sequence s_soft_write;
    i_reg_wr && i_reg_addr == ADDR_SOFT_RESET && i_reg_wdata[0];
  endsequence
  a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read without answer");
  a_no_stray_valid: assert property (!i_reg_rd |=> !o_reg_rvalid && o_reg_rdata == 16'h0000)
    else $error("answer without read");
  a_part_id_fixed: assert property (i_reg_rd && i_reg_addr == ADDR_PART_ID
    |=> o_reg_rdata == {REVISION, PART_ID})
    else $error("identification word wrong");
  a_own_address: assert property (i_reg_rd && i_reg_addr == ADDR_TARGET_ADDR
    |=> o_reg_rdata == {9'h000, TARGET_ADDR[6:0]})
    else $error("target address word wrong");
  a_word_seven: assert property (i_reg_rd && i_reg_addr == ADDR_RESERVED_SEVEN
    |=> o_reg_rdata == 16'h0020)
    else $error("word seven wrong");
  a_soft_pulse: assert property (s_soft_write |=> o_soft_reset ##1 !o_soft_reset)
    else $error("soft reset pulse wrong");
  a_soft_cause: assert property ($rose(o_soft_reset) |-> $past(i_reg_wr))
    else $error("soft reset without write");
  a_result_clip: assert property (s_load_then_read
    |=> o_reg_rdata == sat16($past(i_meas.prox_i, 3)))
    else $error("result word not clipped");
  a_gain_decode: assert property (i_reg_wr && i_reg_addr == ADDR_FE_TRIM
    && i_reg_wdata[1:0] == 2'h0 |-> ##2 o_trim.gain_kohm == 8'hc8)
    else $error("gain decode wrong");
endmodule : sensor_core_register_bank_chk
bind sensor_core_register_bank sensor_core_register_bank_chk #(.PART_ID(PART_ID),
  .REVISION(REVISION), .TARGET_ADDR(TARGET_ADDR)) u_chk (.i_ref_clk, .i_rst, .i_reg_addr,
  .i_reg_wr, .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .i_meas, .i_slot_end,
  .i_slow_osc, .i_fast_tick, .o_trim, .o_soft_reset);
`default_nettype wire

// ---- testbench/sensor_core_register_bank_test.sv ----
// self-checking bench of the sensor core register bank
`timescale 1ns/10ps
`default_nettype none
module sensor_core_register_bank_test;
  import sensor_core_pkg::*;
  localparam logic [11:0] PID = 12'h2b7; // arbitrary value
  localparam logic [3:0] REV = 4'h3; // arbitrary value
  localparam logic [7:0] TADDR = 8'hc8;
  logic i_ref_clk, i_rst, i_reg_wr, i_reg_rd, i_slot_end, i_slow_osc, i_fast_tick;
  logic o_reg_rvalid, o_soft_reset;
  logic [7:0] i_reg_addr;
  logic [15:0] i_reg_wdata, o_reg_rdata;
  logic [19:0] v;
  meas_s i_meas;
  trim_s o_trim;
  logic [15:0] mdl [0:31];
  int cyc, n_mismatch, num_checks;
  int gain_t [4] = '{200, 100, 50, 50};
  int plo_t [4] = '{50, 50, 100, 100};
  int phi_t [4] = '{100, 300, 100, 300};
  int vr_t [4] = '{13, 12, 15, 14};
  sensor_core_host h (.i_ref_clk(i_ref_clk), .o_reg_addr(i_reg_addr), .o_reg_wr(i_reg_wr),
    .o_reg_wdata(i_reg_wdata), .o_reg_rd(i_reg_rd));
  sensor_core_register_bank #(.PART_ID(PID), .REVISION(REV), .TARGET_ADDR(TADDR)) dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .i_meas(i_meas), .i_slot_end(i_slot_end),
    .i_slow_osc(i_slow_osc), .i_fast_tick(i_fast_tick), .o_trim(o_trim),
    .o_soft_reset(o_soft_reset));
  // ----------------------------------------------------------------
  // clock, oscillator stimulus and helpers
  // ----------------------------------------------------------------
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  // ticks sit mid-way between slow edges, so two slow periods hold exactly 20
  always @(posedge i_ref_clk) begin
    #1;
    cyc = cyc + 1;
    i_slow_osc = (cyc % 40) >= 20;
    i_fast_tick = (cyc % 4) == 2;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rst_mdl();
    foreach (mdl[i]) mdl[i] = 16'h0000;
    mdl[7] = 16'h0020;
    mdl[8] = {REV, PID};
    mdl[9] = {9'h000, TADDR[6:0]};
    mdl[12] = 16'h000f;
    mdl[16] = 16'h1010;
    mdl[17] = 16'h004c;
    mdl[18] = 16'h0008;
  endtask : rst_mdl
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    h.write_word(a, d);
    if (a == 8'h0c || a == 8'h10 || a == 8'h11 || a == 8'h12) mdl[a[4:0]] = d;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a);
    h.read_word(a);
    chk("rvalid", 32'h1, {31'h0, o_reg_rvalid});
    chk($sformatf("word %h", a), {16'h0, mdl[a[4:0]]}, {16'h0, o_reg_rdata});
  endtask : rd_chk
  task automatic sweep();
    for (int a = 0; a < 20; a++) if (a != 10) rd_chk(8'(a));
  endtask : sweep
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (100000) @(posedge i_ref_clk);
    n_mismatch++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {cyc, n_mismatch, num_checks} = '0;
    {i_rst, i_slot_end} = 2'b10;
    i_meas = '0;
    void'($urandom(32'hac117cf0));
    rst_mdl();
    repeat (10) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    rd_chk(ADDR_OSC_CAL);
    sweep();
    $display("test reset values done");
    wr(8'h00, 16'h1234);
    wr(8'h07, 16'h0020);
    wr(8'h08, 16'hffff);
    wr(8'h0b, 16'hffff);
    wr(8'h0c, 16'h000f);
    wr(8'h10, 16'h1010);
    wr(8'h11, 16'h004c);
    sweep();
    $display("test writes done");
    for (int k = 0; k < 7; k++) begin
      v = (k % 2) ? (20'h10000 | 20'($urandom)) : 20'($urandom % 20'h10000);
      i_meas = {i_meas[119:0], v};
      mdl[k] = (v > 20'h0ffff) ? 16'hffff : v[15:0];
    end
    @(posedge i_ref_clk);
    #1;
    i_slot_end = 1'b1;
    @(posedge i_ref_clk);
    #1;
    i_slot_end = 1'b0;
    i_meas = ~i_meas;
    rd_chk(ADDR_PROX_I);
    sweep();
    $display("test results done");
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_FE_TRIM, 16'({2'(i + 2), 2'(i + 1), 2'(i)}));
      @(posedge i_ref_clk);
      #1;
      chk("trim", {8'(gain_t[i]), 9'(plo_t[(i + 1) % 4]), 9'(phi_t[(i + 1) % 4]),
        4'(vr_t[(i + 2) % 4])}, 32'(o_trim));
      rd_chk(ADDR_FE_TRIM);
    end
    $display("test trim done");
    wr(ADDR_SOFT_RESET, 16'h0001);
    rst_mdl();
    repeat (2) @(posedge i_ref_clk);
    sweep();
    $display("test soft reset done");
    repeat (300) @(posedge i_ref_clk);
    mdl[10] = 16'd20;
    rd_chk(ADDR_OSC_CAL);
    $display("test calibration done");
    end_of_test();
  end
endmodule : sensor_core_register_bank_test
`default_nettype wire
